// ---- rtl/cpss_pkg.sv ----
package cpss_pkg;
  // clock and time base
  localparam int CLK_HZ = 50_000_000;
  localparam int MS_PER_S = 1000;
  localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam int START_DELAY_MS = 3000;
  localparam int HOLD_MS = 3000;
  localparam int FLASH_HALF_MS = 250;
  localparam int START_DELAY_CYC = START_DELAY_MS * CYC_PER_MS;
  localparam int HOLD_CYC = HOLD_MS * CYC_PER_MS;
  localparam int FLASH_HALF_CYC = FLASH_HALF_MS * CYC_PER_MS;
  localparam int TMR_W = 32;

  // temperature points in whole degrees C
  localparam logic [7:0] T_MIN_C = 8'h19;
  localparam logic [7:0] T_MAX_C = 8'h26;
  localparam logic [7:0] T_FAN_C = 8'h14;
  localparam logic [7:0] T_WARN_C = 8'h32;
  localparam logic [7:0] T_TRIP_C = 8'h41;
  localparam logic [11:0] T_SPAN_C = 12'h00D;

  // motor speed codes
  localparam logic [7:0] SPEED_OFF = 8'h00;
  localparam logic [7:0] SPEED_FULL = 8'hFF;

  // register map (byte addresses)
  localparam logic [11:0] OFS_STATUS = 12'h000;
  localparam logic [11:0] OFS_INT_STAT = 12'h004;
  localparam logic [11:0] OFS_INT_MASK = 12'h008;
  localparam logic [11:0] OFS_FLOW_TMO = 12'h00C;
  localparam logic [11:0] OFS_MIN_SPEED = 12'h010;
  localparam logic [15:0] FLOW_TMO_RST = 16'h03E8;
  localparam logic [7:0] MIN_SPEED_RST = 8'h40;
  localparam int NUM_PIN = 4;
  // pin idle levels, override pin rests high
  localparam logic [NUM_PIN-1:0] PIN_IDLE = 4'h1;
  localparam int NUM_EV = 5;

  typedef enum logic [2:0] {
    ST_EMPTY = 3'b001,
    ST_FILLED = 3'b010,
    ST_RUN = 3'b100
  } cpss_state_e;

  typedef struct packed {
    logic level_ok;
    logic flow;
    logic uv;
    logic ovr_n;
  } cpss_sense_s;

  typedef struct packed {
    logic trip;
    logic warn;
    logic uv;
    logic flow;
    logic empty;
  } cpss_ev_s;

  typedef struct packed {
    logic red;
    logic blue;
  } cpss_lamp_s;

  typedef struct packed {
    logic [15:0] zero;
    logic [7:0] pump_speed;
    logic ovr;
    logic trip;
    logic warn;
    logic flow_fault;
    logic uv;
    logic running;
    logic filled;
    logic level_ok;
  } cpss_status_s;
endpackage : cpss_pkg

// ---- rtl/cpss_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpss_timer (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  // control
  input wire logic start,
  input wire logic reload,
  input wire logic [cpss_pkg::TMR_W-1:0] period,
  // status
  output logic done,
  output logic busy
);
  logic [cpss_pkg::TMR_W-1:0] cnt_q;
  logic busy_q;
  logic done_q;
  wire logic last = cnt_q <= {{(cpss_pkg::TMR_W-1){1'b0}}, 1'b1};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (ce) begin
      done_q <= busy_q && last && !start;
      if (start) begin
        cnt_q <= period;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        cnt_q <= last ? period : cnt_q - {{(cpss_pkg::TMR_W-1){1'b0}}, 1'b1};
        busy_q <= !last || reload;
      end
    end
  end

  assign done = done_q;
  assign busy = busy_q;
endmodule : cpss_timer
`default_nettype wire

// ---- rtl/cpss_top.sv ----
// Overview of operation
// R1 - empty reservoir: pump stopped, lamp blue flashing
// R2 - minimum level reached: lamp turns steady red
// R3 - after delay pump starts full, lamp blue
// R4 - power-up: full speed, then temperature regulation
// R5 - level lost while running: stop, blue flashing
// R6 - override pin low forces full motor speed
// R7 - speed ramps min at 25C to max 38C
// R8 - fan output off below 20C
// R9 - undervoltage: stop motors, blue flash, relay closed
// R10 - flow pulses stop: lamp red, relay fault
// R11 - above 50C lamp violet, no fault
// R12 - at 65C red flashing, relay fault
// R13 - relay closed on any fault or unpowered
// R14 - open-collector fault output low on fault
// R15 - delays counted in cycles from parameters
// R16 - lamp priority: trip, flow, blue flash, steady red, violet, blue
`timescale 1ns/1ps
`default_nettype none
module cpss_top #(
  parameter int START_DELAY_CYC = cpss_pkg::START_DELAY_CYC,
  parameter int HOLD_CYC = cpss_pkg::HOLD_CYC,
  parameter int FLASH_HALF_CYC = cpss_pkg::FLASH_HALF_CYC,
  parameter int MS_CYC = cpss_pkg::CYC_PER_MS
) (
  // clock, reset, enable
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sensor pins
  input wire logic level_ok,
  input wire logic flow_pulse,
  input wire logic uv_det,
  input wire logic speed_ovr_n,
  // coolant temperature, same clock
  input wire logic [7:0] temp_c,
  // motors
  output logic [7:0] pump_speed,
  output logic [7:0] fan_speed,
  // lamp and fault outputs
  output logic lamp_red,
  output logic lamp_blue,
  output logic relay_closed,
  output logic fault_oc_o,
  output logic fault_oc_oe,
  output logic irq
);
  // reset release
  logic rst_meta_q;
  logic rst_n_q;
  wire logic rst_n = rst_n_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // pin synchronisers
  logic [cpss_pkg::NUM_PIN-1:0] pin_raw;
  logic [cpss_pkg::NUM_PIN-1:0] meta_q;
  logic [cpss_pkg::NUM_PIN-1:0] sync_q;
  assign pin_raw = {level_ok, flow_pulse, uv_det, speed_ovr_n};

  for (genvar i = 0; i < cpss_pkg::NUM_PIN; i++) begin : g_sync
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        meta_q[i] <= cpss_pkg::PIN_IDLE[i];
        sync_q[i] <= cpss_pkg::PIN_IDLE[i];
      end else if (ce) begin
        meta_q[i] <= pin_raw[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  cpss_pkg::cpss_sense_s sense;
  assign sense = cpss_pkg::cpss_sense_s'(sync_q);

  // state and registers
  cpss_pkg::cpss_state_e st_q;
  cpss_pkg::cpss_state_e st_d;
  cpss_pkg::cpss_lamp_s lamp_q;
  cpss_pkg::cpss_lamp_s lamp_d;
  logic por_done_q;
  logic flash_ph_q;
  logic flow_prev_q;
  logic flow_fault_q;
  logic [15:0] flow_ms_q;
  logic [15:0] flow_tmo_q;
  logic [7:0] min_speed_q;
  logic [cpss_pkg::NUM_EV-1:0] int_stat_q;
  logic [cpss_pkg::NUM_EV-1:0] int_mask_q;
  logic [cpss_pkg::NUM_EV-1:0] lvl_prev_q;
  logic [7:0] pump_speed_q;
  logic [7:0] fan_speed_q;
  logic relay_q;
  logic irq_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // timers
  logic flash_done;
  logic flash_busy;
  logic ms_tick;
  logic ms_busy;
  logic start_done;
  logic hold_busy;

  wire logic in_empty = st_q == cpss_pkg::ST_EMPTY;
  wire logic in_filled = st_q == cpss_pkg::ST_FILLED;
  wire logic in_run = st_q == cpss_pkg::ST_RUN;
  wire logic enter_fill = in_empty && sense.level_ok;
  wire logic enter_run = in_filled && sense.level_ok && start_done;
  wire logic running = in_run && !sense.uv;
  wire logic ovr = !sense.ovr_n;
  wire logic warn = temp_c > cpss_pkg::T_WARN_C;
  wire logic trip = temp_c >= cpss_pkg::T_TRIP_C;

  cpss_timer u_flash (
    .clock(clock), .rst_n(rst_n), .ce(ce),
    .start(!flash_busy), .reload(1'b1), .period(32'(FLASH_HALF_CYC)),
    .done(flash_done), .busy(flash_busy)
  );

  cpss_timer u_ms (
    .clock(clock), .rst_n(rst_n), .ce(ce),
    .start(!ms_busy), .reload(1'b1), .period(32'(MS_CYC)),
    .done(ms_tick), .busy(ms_busy)
  );

  // start delay from minimum level to pump start
  cpss_timer u_start (
    .clock(clock), .rst_n(rst_n), .ce(ce),
    .start(enter_fill), .reload(1'b0), .period(32'(START_DELAY_CYC)), // [R15]
    .done(start_done), .busy()
  );

  // full-speed hold at power-up and at each pump start from ST_FILLED, not on restart after undervoltage
  cpss_timer u_hold (
    .clock(clock), .rst_n(rst_n), .ce(ce),
    .start(!por_done_q || enter_run), .reload(1'b0), .period(32'(HOLD_CYC)), // [R4] [R15]
    .done(), .busy(hold_busy)
  );

  // fill sequence
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      cpss_pkg::ST_EMPTY: begin
        if (sense.level_ok) st_d = cpss_pkg::ST_FILLED; // [R2]
      end
      cpss_pkg::ST_FILLED: begin
        if (!sense.level_ok) st_d = cpss_pkg::ST_EMPTY;
        else if (start_done) st_d = cpss_pkg::ST_RUN; // [R3]
      end
      cpss_pkg::ST_RUN: begin
        if (!sense.level_ok) st_d = cpss_pkg::ST_EMPTY; // [R5]
      end
    endcase
  end

  // temperature ramp
  wire logic [3:0] t_ofs = 4'(temp_c - cpss_pkg::T_MIN_C);
  wire logic [7:0] span = cpss_pkg::SPEED_FULL - min_speed_q;
  wire logic [11:0] prod = 12'(t_ofs) * 12'(span);
  wire logic [11:0] ramp = prod / cpss_pkg::T_SPAN_C;
  wire logic [7:0] auto_speed = temp_c <= cpss_pkg::T_MIN_C ? min_speed_q :
                                temp_c >= cpss_pkg::T_MAX_C ? cpss_pkg::SPEED_FULL :
                                min_speed_q + ramp[7:0]; // [R7]
  wire logic force_full = hold_busy || ovr; // [R4] [R6]
  wire logic [7:0] motor_speed = force_full ? cpss_pkg::SPEED_FULL : auto_speed;
  wire logic [7:0] pump_speed_d = running ? motor_speed : cpss_pkg::SPEED_OFF; // [R1] [R9]
  wire logic fan_off = sense.uv || temp_c < cpss_pkg::T_FAN_C; // [R8] [R9]
  wire logic [7:0] fan_speed_d = fan_off ? cpss_pkg::SPEED_OFF : motor_speed;

  // flow supervision
  wire logic flow_edge = sense.flow && !flow_prev_q;
  wire logic flow_late = flow_ms_q >= flow_tmo_q;
  wire logic flow_fault_d = running && !flow_edge && (flow_fault_q || (flow_late && ms_tick)); // [R10]

  // fault and lamp
  wire logic fault = sense.uv || flow_fault_q || trip || !in_run; // [R13]
  always_comb begin
    lamp_d = '0;
    if (trip) lamp_d.red = flash_ph_q; // [R12] [R16]
    else if (flow_fault_q) lamp_d.red = 1'b1; // [R10] [R16]
    else if (sense.uv || in_empty) lamp_d.blue = flash_ph_q; // [R1] [R5] [R9] [R16]
    else if (in_filled) lamp_d.red = 1'b1; // [R2]
    else if (warn) lamp_d = '1; // [R11] [R16]
    else lamp_d.blue = 1'b1; // [R3]
  end

  // events and interrupt
  cpss_pkg::cpss_ev_s lvl;
  assign lvl = '{trip: trip, warn: warn, uv: sense.uv, flow: flow_fault_q, empty: in_empty};
  wire logic [cpss_pkg::NUM_EV-1:0] ev = lvl & ~lvl_prev_q;

  // apb decode
  wire logic acc = psel && penable;
  wire logic take = acc && pready_q;
  wire logic wr = take && pwrite;
  wire logic hit_status = paddr == cpss_pkg::OFS_STATUS;
  wire logic hit_stat = paddr == cpss_pkg::OFS_INT_STAT;
  wire logic hit_mask = paddr == cpss_pkg::OFS_INT_MASK;
  wire logic hit_tmo = paddr == cpss_pkg::OFS_FLOW_TMO;
  wire logic hit_min = paddr == cpss_pkg::OFS_MIN_SPEED;
  wire logic mapped = hit_status || hit_stat || hit_mask || hit_tmo || hit_min;
  wire logic [cpss_pkg::NUM_EV-1:0] w1c = (wr && hit_stat) ? pwdata[cpss_pkg::NUM_EV-1:0] : '0;
  wire logic [cpss_pkg::NUM_EV-1:0] int_stat_d = (int_stat_q & ~w1c) | ev;

  cpss_pkg::cpss_status_s status;
  assign status = '{zero: '0, pump_speed: pump_speed_q, ovr: ovr, trip: trip, warn: warn,
                    flow_fault: flow_fault_q, uv: sense.uv, running: running,
                    filled: in_filled, level_ok: sense.level_ok};
  wire logic [31:0] rdata = hit_status ? 32'(status) :
                            hit_stat ? 32'(int_stat_q) :
                            hit_mask ? 32'(int_mask_q) :
                            hit_tmo ? 32'(flow_tmo_q) :
                            hit_min ? 32'(min_speed_q) : '0;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= cpss_pkg::ST_EMPTY;
      por_done_q <= 1'b0;
      flash_ph_q <= 1'b0;
      flow_prev_q <= 1'b0;
      flow_fault_q <= 1'b0;
      flow_ms_q <= '0;
      lvl_prev_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
      por_done_q <= 1'b1;
      flash_ph_q <= flash_ph_q ^ flash_done;
      flow_prev_q <= sense.flow;
      flow_fault_q <= flow_fault_d;
      flow_ms_q <= (!running || flow_edge) ? '0 : flow_ms_q + 16'(ms_tick && !flow_late);
      lvl_prev_q <= lvl;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pump_speed_q <= cpss_pkg::SPEED_OFF;
      fan_speed_q <= cpss_pkg::SPEED_OFF;
      lamp_q <= '0;
      relay_q <= 1'b1;
      irq_q <= 1'b0;
    end else if (ce) begin
      pump_speed_q <= pump_speed_d;
      fan_speed_q <= fan_speed_d;
      lamp_q <= lamp_d;
      relay_q <= fault; // [R13]
      irq_q <= |(int_stat_q & int_mask_q);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      int_stat_q <= '0;
      int_mask_q <= '0;
      flow_tmo_q <= cpss_pkg::FLOW_TMO_RST;
      min_speed_q <= cpss_pkg::MIN_SPEED_RST;
    end else if (ce) begin
      int_stat_q <= int_stat_d;
      if (wr && hit_mask) int_mask_q <= pwdata[cpss_pkg::NUM_EV-1:0];
      if (wr && hit_tmo) flow_tmo_q <= pwdata[15:0];
      if (wr && hit_min) min_speed_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      pready_q <= acc && !pready_q;
      if (acc && !pready_q) begin
        prdata_q <= pwrite ? '0 : rdata;
        pslverr_q <= !mapped;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pump_speed = pump_speed_q;
  assign fan_speed = fan_speed_q;
  assign lamp_red = lamp_q.red;
  assign lamp_blue = lamp_q.blue;
  assign relay_closed = relay_q;
  assign fault_oc_oe = relay_q; // [R14]
  assign fault_oc_o = 1'b0;
  assign irq = irq_q;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n || !ce);

  sequence s_start;
    in_filled && sense.level_ok && start_done && !sense.uv;
  endsequence
  sequence s_run_cold;
    running && !force_full && temp_c <= cpss_pkg::T_MIN_C;
  endsequence

  AST_EMPTY_STOP: assert property (in_empty |=> pump_speed_q == cpss_pkg::SPEED_OFF) // [R1]
    else $error("pump running while empty");
  AST_EMPTY_LAMP: assert property (in_empty && !trip && !flow_fault_q |=>
    !lamp_q.red && lamp_q.blue == $past(flash_ph_q)) // [R1]
    else $error("empty lamp not blue flashing");
  AST_FILL_RED: assert property (in_filled && !sense.uv && !trip |=> lamp_q.red && !lamp_q.blue) // [R2]
    else $error("filled lamp not red");
  AST_START_FULL: assert property (s_start ##1 running |=> pump_speed_q == cpss_pkg::SPEED_FULL) // [R3]
    else $error("pump not full at start");
  AST_HOLD_FULL: assert property (hold_busy && running |=> pump_speed_q == cpss_pkg::SPEED_FULL) // [R4]
    else $error("hold time not full speed");
  AST_REFILL: assert property (in_run && !sense.level_ok |=> in_empty ##1
    pump_speed_q == cpss_pkg::SPEED_OFF) // [R5]
    else $error("pump not stopped on level loss");
  AST_OVERRIDE: assert property (ovr && running |=> pump_speed_q == cpss_pkg::SPEED_FULL) // [R6]
    else $error("override not full speed");
  AST_COLD_MIN: assert property (s_run_cold |=> pump_speed_q == $past(min_speed_q)) // [R7]
    else $error("cold speed not minimum");
  AST_HOT_MAX: assert property (running && temp_c >= cpss_pkg::T_MAX_C |=>
    pump_speed_q == cpss_pkg::SPEED_FULL) // [R7]
    else $error("hot speed not maximum");
  AST_FAN_COLD: assert property (temp_c < cpss_pkg::T_FAN_C |=> fan_speed_q == cpss_pkg::SPEED_OFF) // [R8]
    else $error("fan on below threshold");
  AST_UV_STOP: assert property (sense.uv |=> pump_speed_q == cpss_pkg::SPEED_OFF &&
    fan_speed_q == cpss_pkg::SPEED_OFF && relay_q) // [R9]
    else $error("undervoltage not handled");
  AST_FLOW: assert property (flow_fault_q && !trip |=> lamp_q.red && !lamp_q.blue && relay_q) // [R10]
    else $error("flow fault not shown");
  AST_WARN: assert property (warn && !trip && running && !flow_fault_q |=> lamp_q.red && lamp_q.blue) // [R11]
    else $error("warning lamp not violet");
  AST_TRIP: assert property (trip |=> relay_q && !lamp_q.blue && lamp_q.red == $past(flash_ph_q)) // [R12]
    else $error("overtemperature not handled");
  AST_RELAY_RUN: assert property (!in_run |=> relay_q && fault_oc_oe) // [R13] [R14]
    else $error("relay open outside run");
endmodule : cpss_top
`default_nettype wire

// ---- tb/cpss_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpss_partner (
  // clock
  input wire logic clock,
  // pump drive and fault injection
  input wire logic [7:0] pump_speed,
  input wire logic stall,
  // turbine sensor
  output logic flow_pulse
);
  logic [1:0] cnt_q = 2'h0;
  // turbine turns only while the pump runs and no blockage is injected
  always_ff @(posedge clock) begin
    if (pump_speed != 8'h00 && !stall) begin
      cnt_q <= cnt_q + 2'h1;
    end
  end
  assign flow_pulse = cnt_q[1];
endmodule : cpss_partner
`default_nettype wire

// ---- tb/tb_coolant_pump_safety_supervisor.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_coolant_pump_safety_supervisor;
  localparam int START_CYC = 40;
  localparam int HOLD_CYC = 30;
  localparam int FLASH_CYC = 8;
  logic clock, rst_b, psel, penable, pwrite, pready, pslverr, e;
  logic level_ok, uv_det, speed_ovr_n, stall, flow_pulse;
  logic lamp_red, lamp_blue, relay_closed, fault_oc_o, fault_oc_oe, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0] temp_c, pump_speed, fan_speed;
  logic [3:0] lamp;
  int n_mismatch = 0;
  int comparisons = 0;
  int temps [7] = '{19, 20, 25, 26, 31, 37, 38};

  cpss_top #(.START_DELAY_CYC(START_CYC), .HOLD_CYC(HOLD_CYC), .FLASH_HALF_CYC(FLASH_CYC), .MS_CYC(4)) i_dut (
    .clock(clock), .rst_b(rst_b), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .level_ok(level_ok), .flow_pulse(flow_pulse), .uv_det(uv_det), .speed_ovr_n(speed_ovr_n),
    .temp_c(temp_c), .pump_speed(pump_speed), .fan_speed(fan_speed),
    .lamp_red(lamp_red), .lamp_blue(lamp_blue), .relay_closed(relay_closed),
    .fault_oc_o(fault_oc_o), .fault_oc_oe(fault_oc_oe), .irq(irq)
  );

  cpss_partner i_partner (.clock(clock), .pump_speed(pump_speed), .stall(stall), .flow_pulse(flow_pulse));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic print_verdict;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      n_mismatch++;
      $display("ERROR %0t: seen %h expected %h", $time, s, x);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask : wt

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    chk(pready, 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask : rd

  // collects {red seen, red always, blue seen, blue always} over two flash half-periods plus four cycles
  task automatic lamp_seen;
    lamp = 4'b0101;
    repeat (2 * FLASH_CYC + 4) begin
      @(posedge clock);
      lamp = lamp | {lamp_red, 1'b0, lamp_blue, 1'b0};
      lamp = lamp & {1'b1, lamp_red, 1'b1, lamp_blue};
    end
  endtask : lamp_seen

  function automatic logic [7:0] exp_spd(input int t);
    if (t <= 25) return cpss_pkg::MIN_SPEED_RST;
    if (t >= 38) return 8'hFF;
    return 8'(64 + ((t - 25) * 191) / 13);
  endfunction : exp_spd

  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    level_ok = 1'b0;
    uv_det = 1'b0;
    speed_ovr_n = 1'b1;
    stall = 1'b0;
    temp_c = 8'h1E;
    wt(5);
    rst_b <= 1'b1;
    wt(6);
    chk(fan_speed, 8'hFF);
    chk(pump_speed, 8'h00);
    chk({relay_closed, fault_oc_oe, fault_oc_o}, 3'b110);
    lamp_seen();
    chk(lamp, 4'b0010);
    rd(cpss_pkg::OFS_INT_MASK, 32'h0);
    rd(cpss_pkg::OFS_FLOW_TMO, 32'h3E8);
    rd(cpss_pkg::OFS_MIN_SPEED, 32'h40);
    apb(1'b0, 12'h0FC, 32'h0);
    chk({e, q}, {1'b1, 32'h0});
    apb(1'b1, cpss_pkg::OFS_STATUS, 32'hFFFF_FFFF);
    chk(e, 1'b0);
    wt(HOLD_CYC);
    chk(fan_speed, exp_spd(30));
    level_ok <= 1'b1;
    wt(6);
    lamp_seen();
    chk(lamp, 4'b1100);
    chk(pump_speed, 8'h00);
    wt(START_CYC);
    chk(pump_speed, 8'hFF);
    lamp_seen();
    chk(lamp, 4'b0011);
    wt(HOLD_CYC);
    chk(pump_speed, exp_spd(30));
    chk({relay_closed, fault_oc_oe}, 2'b00);
    foreach (temps[i]) begin
      temp_c <= 8'(temps[i]);
      wt(4);
      chk(pump_speed, exp_spd(temps[i]));
      chk(fan_speed, (temps[i] < 20) ? 8'h00 : exp_spd(temps[i]));
    end
    temp_c <= 8'h1E;
    speed_ovr_n <= 1'b0;
    wt(6);
    chk({pump_speed, fan_speed}, 16'hFFFF);
    temp_c <= 8'h13;
    wt(4);
    chk(fan_speed, 8'h00);
    speed_ovr_n <= 1'b1;
    temp_c <= 8'h33;
    wt(4);
    lamp_seen();
    chk({lamp, relay_closed}, 5'b11110);
    temp_c <= 8'h41;
    wt(4);
    lamp_seen();
    chk({lamp, relay_closed, fault_oc_oe}, 6'b100011);
    temp_c <= 8'h1E;
    wt(4);
    apb(1'b1, cpss_pkg::OFS_INT_STAT, 32'h1F);
    apb(1'b1, cpss_pkg::OFS_FLOW_TMO, 32'h3);
    stall <= 1'b1;
    wt(30);
    lamp_seen();
    chk({lamp, relay_closed, fault_oc_oe}, 6'b110011);
    rd(cpss_pkg::OFS_INT_STAT, 32'h2);
    chk(irq, 1'b0);
    apb(1'b1, cpss_pkg::OFS_INT_MASK, 32'h2);
    wt(2);
    chk(irq, 1'b1);
    apb(1'b1, cpss_pkg::OFS_INT_STAT, 32'h2);
    wt(2);
    chk(irq, 1'b0);
    stall <= 1'b0;
    wt(10);
    chk(relay_closed, 1'b0);
    uv_det <= 1'b1;
    wt(6);
    chk({pump_speed, fan_speed, relay_closed}, 17'h00001);
    lamp_seen();
    chk(lamp, 4'b0010);
    uv_det <= 1'b0;
    wt(8);
    chk(pump_speed, exp_spd(30));
    level_ok <= 1'b0;
    wt(6);
    chk(pump_speed, 8'h00);
    lamp_seen();
    chk(lamp, 4'b0010);
    apb(1'b0, cpss_pkg::OFS_INT_STAT, 32'h0);
    chk(q[2:0] & 3'b101, 3'b101);
    print_verdict();
  end

  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    print_verdict();
  end
endmodule : tb_coolant_pump_safety_supervisor
`default_nettype wire
